// >>> charge_seq_pkg.sv
// constants, register layout and state type for the single-cell charge sequencer
// assumes a 10 MHz system clock and a simple byte-wide register port
`default_nettype none
package charge_seq_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SEC_PER_MIN = 60;
    localparam int MIN_PER_HOUR = 60;
    localparam int PREQUAL_LIMIT_H = 1;
    localparam int SAFETY_LIMIT_H = 10;
    localparam int TOPOFF_MIN = 21;
    localparam int PREQUAL_LIMIT_S = PREQUAL_LIMIT_H * MIN_PER_HOUR * SEC_PER_MIN;
    localparam int SAFETY_LIMIT_S = SAFETY_LIMIT_H * MIN_PER_HOUR * SEC_PER_MIN;
    localparam int TOPOFF_S = TOPOFF_MIN * SEC_PER_MIN;
    localparam int SEC_W = 16;

    localparam logic [7:0] ADDR_CHARGE_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_CHARGER_SUPERVISOR = 8'h02;

    // charge_control fields
    localparam int CTL_TERM_HI = 7;
    localparam int CTL_TERM_LO = 6;
    localparam int CTL_ICC_HI = 5;
    localparam int CTL_ICC_LO = 2;
    localparam int CTL_EN_BIT = 1;
    localparam int CTL_EOC_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h43;

    // charger_supervisor fields
    localparam int SPV_LED_CUR_BIT = 5;
    localparam int SPV_LED_EN_BIT = 4;
    localparam int SPV_RANGE_BIT = 3;
    localparam logic [2:0] SPV_RW_RESET = 3'h6;

    localparam logic [1:0] TERM_4V10 = 2'h0;
    localparam logic [1:0] TERM_4V20 = 2'h1;
    localparam logic [1:0] TERM_4V38 = 2'h2;
    localparam logic [12:0] MV_3900 = 13'h0F3C;
    localparam logic [12:0] MV_4000 = 13'h0FA0;
    localparam logic [12:0] MV_4100 = 13'h1004;
    localparam logic [12:0] MV_4200 = 13'h1068;
    localparam logic [12:0] MV_4380 = 13'h111C;

    localparam logic [3:0] ICC_MAX_CODE = 4'h9;
    localparam int ICC_STEP_MA = 100;
    localparam logic [10:0] USB_PREQUAL_MA = 11'h032;
    localparam int PREQUAL_DIV = 10;
    localparam int EOC_DIV_LOW = 20;
    localparam int EOC_DIV_HIGH = 10;

    localparam logic [2:0] CODE_OFF = 3'h0;
    localparam logic [2:0] CODE_PREQUAL = 3'h1;
    localparam logic [2:0] CODE_CC = 3'h2;
    localparam logic [2:0] CODE_CV = 3'h3;
    localparam logic [2:0] CODE_ERROR = 3'h4;
    localparam logic [2:0] CODE_DONE = 3'h5;
    localparam logic [2:0] CODE_TIMER = 3'h6;
    localparam logic [2:0] CODE_TOPOFF = 3'h7;

    typedef enum {ST_OFF, ST_PREQUAL, ST_CC, ST_CV, ST_TOPOFF, ST_DONE, ST_TEMP_ERR,
                  ST_TIMER_EXP} charge_state_t;
endpackage : charge_seq_pkg
`default_nettype wire

// >>> batt_temp_window.sv
// battery temperature window with hysteresis from the thermistor comparators
// assumes comparator levels are synchronous to i_clk; float flag is a comparator too
`default_nettype none
module batt_temp_window (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_range45,
    input wire logic i_cold_trip,
    input wire logic i_cold_clear,
    input wire logic i_hot45_trip,
    input wire logic i_hot45_clear,
    input wire logic i_hot50_trip,
    input wire logic i_hot50_clear,
    input wire logic i_ts_float,
    output logic o_in_range
);
    logic trip;
    logic release_ok;

    // a floating thermistor counts as past the limit
    assign trip = i_ts_float | i_cold_trip | (i_range45 ? i_hot45_trip : i_hot50_trip);
    // the clear comparators sit 3 degrees inside each threshold
    assign release_ok = !i_ts_float & i_cold_clear &
                        (i_range45 ? i_hot45_clear : i_hot50_clear);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_in_range <= 1'b0;
        end else if (trip) begin
            o_in_range <= 1'b0;
        end else if (release_ok) begin
            o_in_range <= 1'b1;
        end
    end

    AST_FLOAT_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ts_float |=> !o_in_range)
        else $error("floating thermistor left window open");
    AST_HYST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_in_range && !release_ok) |=> !o_in_range)
        else $error("window reopened inside hysteresis band");
endmodule : batt_temp_window
`default_nettype wire

// >>> li_ion_charge_sequencer.sv
// charge state sequencer, safety timer and charger registers
// assumes comparator inputs and register strobes are synchronous to i_clk
//
// Behaviour
// - termination code 00/01/10, reset 01
// - current code in 100 mA steps, reset 0000
// - enable clear halts charging, state zero
// - end-of-charge threshold 5% or 10%, reset 10%
// - prequal at 10% adapter or 50 mA USB
// - prequal exit goes to constant current
// - termination voltage reached goes constant voltage
// - end-of-charge starts 21 minute top-off, code 111
// - cycle complete disables charging, code 101
// - below restart resumes constant current directly
// - range bit selects 50 or 45 degrees
// - temperature out of window suspends, code 100
// - three degrees hysteresis on each threshold
// - floating thermistor treated as out of range
// - prequal limited to one hour
// - total charging limited to ten hours
// - timer expiry raises interrupt, visible to software
// - timer restarts on source, recharge, enable toggle
// - timer restarts after shutdown, temperature, suspend
// - restart threshold follows termination voltage
// - adapter takes priority over USB
`default_nettype none
module li_ion_charge_sequencer
    import charge_seq_pkg::*;
#(
    parameter int CYCLES_PER_SEC = CLK_HZ
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_adapter_supply_input,
    input wire logic i_usb_supply_input,
    input wire logic i_usb_suspend_input,
    input wire logic i_batt_above_fullrate,
    input wire logic i_batt_at_term,
    input wire logic i_batt_below_restart,
    input wire logic i_eoc_reached,
    input wire logic i_thermal_shutdown,
    input wire logic i_cold_trip,
    input wire logic i_cold_clear,
    input wire logic i_hot45_trip,
    input wire logic i_hot45_clear,
    input wire logic i_hot50_trip,
    input wire logic i_hot50_clear,
    input wire logic i_ts_float,
    output logic [7:0] o_reg_rdata,
    output logic [2:0] o_charge_state,
    output logic o_charge_pass_transistor,
    output logic o_charge_from_usb,
    output logic [10:0] o_charge_current_ma,
    output logic [10:0] o_eoc_current_ma,
    output logic [12:0] o_term_mv,
    output logic [12:0] o_recharge_threshold_mv,
    output logic o_led_enable,
    output logic o_led_current_high,
    output logic o_safety_timer_expired,
    output logic o_irq
);
    import charge_seq_pkg::*;

    function automatic logic [2:0] state_code(input charge_state_t s);
        case (s)
            ST_PREQUAL: state_code = CODE_PREQUAL;
            ST_CC: state_code = CODE_CC;
            ST_CV: state_code = CODE_CV;
            ST_TOPOFF: state_code = CODE_TOPOFF;
            ST_DONE: state_code = CODE_DONE;
            ST_TEMP_ERR: state_code = CODE_ERROR;
            ST_TIMER_EXP: state_code = CODE_TIMER;
            default: state_code = CODE_OFF;
        endcase
    endfunction : state_code

    function automatic logic [10:0] icc_ma(input logic [3:0] code);
        logic [3:0] c;
        c = (code > ICC_MAX_CODE) ? ICC_MAX_CODE : code;
        icc_ma = 11'((int'(c) + 1) * ICC_STEP_MA);
    endfunction : icc_ma

    function automatic logic [12:0] term_mv(input logic [1:0] code);
        // reserved code falls back to the reset selection
        if (code == TERM_4V10) begin
            term_mv = MV_4100;
        end else if (code == TERM_4V38) begin
            term_mv = MV_4380;
        end else begin
            term_mv = MV_4200;
        end
    endfunction : term_mv

    function automatic logic [12:0] restart_mv(input logic [1:0] code);
        if (code == TERM_4V10) begin
            restart_mv = MV_3900;
        end else if (code == TERM_4V38) begin
            restart_mv = MV_4200;
        end else begin
            restart_mv = MV_4000;
        end
    endfunction : restart_mv

    logic [1:0] rst_sync;
    logic rst_n;
    logic [7:0] ctl;
    logic [2:0] spv;
    charge_state_t state;
    charge_state_t next_state;
    logic [23:0] div_cnt;
    logic sec_tick;
    logic [SEC_W-1:0] safety_sec;
    logic [SEC_W-1:0] topoff_sec;
    logic src_prev;
    logic usb_prev;
    logic en_prev;
    logic tsd_prev;
    logic temp_prev;
    logic susp_prev;
    logic temp_ok;
    logic src;
    logic use_usb;
    logic en;
    logic timer_restart;
    logic expire;
    logic charging;
    logic [10:0] full_rate_current;

    // reset is released through two flops so its removal is clean
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    batt_temp_window u_temp (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_range45(spv[0]),
        .i_cold_trip(i_cold_trip),
        .i_cold_clear(i_cold_clear),
        .i_hot45_trip(i_hot45_trip),
        .i_hot45_clear(i_hot45_clear),
        .i_hot50_trip(i_hot50_trip),
        .i_hot50_clear(i_hot50_clear),
        .i_ts_float(i_ts_float),
        .o_in_range(temp_ok)
    );

    assign src = i_adapter_supply_input | (i_usb_supply_input & !i_usb_suspend_input);
    assign use_usb = !i_adapter_supply_input;
    assign en = ctl[CTL_EN_BIT];
    assign full_rate_current = icc_ma(ctl[CTL_ICC_HI:CTL_ICC_LO]);

    // register writes; supervisor status bits are read only
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= CTL_RESET;
            spv <= SPV_RW_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_CHARGE_CONTROL) begin
                ctl <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_CHARGER_SUPERVISOR) begin
                spv <= i_reg_wdata[SPV_LED_CUR_BIT:SPV_RANGE_BIT];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (i_reg_addr == ADDR_CHARGE_CONTROL) begin
                o_reg_rdata <= ctl;
            end else if (i_reg_addr == ADDR_CHARGER_SUPERVISOR) begin
                o_reg_rdata <= {2'b00, spv, state_code(state)};
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // one-second enable keeps the hour-scale counters narrow
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 24'h00_0000;
            sec_tick <= 1'b0;
        end else if (div_cnt == 24'(CYCLES_PER_SEC - 1)) begin
            div_cnt <= 24'h00_0000;
            sec_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 24'h00_0001;
            sec_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev <= 1'b0;
            usb_prev <= 1'b0;
            en_prev <= 1'b1;
            tsd_prev <= 1'b0;
            temp_prev <= 1'b0;
            susp_prev <= 1'b0;
        end else begin
            src_prev <= src;
            usb_prev <= use_usb;
            en_prev <= en;
            tsd_prev <= i_thermal_shutdown;
            temp_prev <= temp_ok;
            susp_prev <= i_usb_suspend_input;
        end
    end

    always_comb begin
        timer_restart = (src & !src_prev)
            | (src & src_prev & (use_usb != usb_prev))
            | (state == ST_DONE & i_batt_below_restart & en)
            | (en & !en_prev)
            | (!i_thermal_shutdown & tsd_prev)
            | (temp_ok & !temp_prev & en)
            | (!i_usb_suspend_input & susp_prev & use_usb);
    end

    assign charging = (state == ST_PREQUAL) | (state == ST_CC) | (state == ST_CV) |
                      (state == ST_TOPOFF);

    // the one counter covers prequal and the rest, so the ten hour limit
    // already subtracts time spent in prequal
    assign expire = charging & ((state == ST_PREQUAL) ?
                    (safety_sec >= SEC_W'(PREQUAL_LIMIT_S)) :
                    (safety_sec >= SEC_W'(SAFETY_LIMIT_S)));

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            safety_sec <= '0;
        end else if (timer_restart) begin
            safety_sec <= '0;
        end else if (charging & sec_tick & !expire) begin
            safety_sec <= safety_sec + SEC_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            topoff_sec <= '0;
        end else if (state != ST_TOPOFF) begin
            topoff_sec <= '0;
        end else if (sec_tick) begin
            topoff_sec <= topoff_sec + SEC_W'(1);
        end
    end

    always_comb begin
        next_state = state;
        if (!src || !en) begin
            next_state = ST_OFF;
        end else if (state == ST_TIMER_EXP && !timer_restart) begin
            next_state = ST_TIMER_EXP;
        end else if (state == ST_DONE) begin
            if (i_batt_below_restart) begin
                next_state = ST_CC;
            end
        end else if (!temp_ok || i_thermal_shutdown) begin
            next_state = ST_TEMP_ERR;
        end else if (expire) begin
            next_state = ST_TIMER_EXP;
        end else begin
            case (state)
                ST_PREQUAL: begin
                    if (i_batt_above_fullrate) begin
                        next_state = ST_CC;
                    end
                end
                ST_CC: begin
                    if (i_batt_at_term) begin
                        next_state = ST_CV;
                    end
                end
                ST_CV: begin
                    if (i_eoc_reached) begin
                        next_state = ST_TOPOFF;
                    end
                end
                ST_TOPOFF: begin
                    if (topoff_sec >= SEC_W'(TOPOFF_S)) begin
                        next_state = ST_DONE;
                    end
                end
                default: begin
                    next_state = i_batt_above_fullrate ? ST_CC : ST_PREQUAL;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            o_charge_state <= CODE_OFF;
        end else begin
            state <= next_state;
            o_charge_state <= state_code(next_state);
        end
    end

    // pass transistor and current setpoint follow the state being entered
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_charge_pass_transistor <= 1'b0;
            o_charge_current_ma <= 11'h000;
        end else begin
            o_charge_pass_transistor <= (next_state == ST_PREQUAL) | (next_state == ST_CC) |
                (next_state == ST_CV) | (next_state == ST_TOPOFF);
            if (next_state == ST_PREQUAL) begin
                o_charge_current_ma <= use_usb ? USB_PREQUAL_MA :
                                       11'(full_rate_current / 11'(PREQUAL_DIV));
            end else begin
                o_charge_current_ma <= full_rate_current;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_charge_from_usb <= 1'b0;
            o_eoc_current_ma <= 11'h000;
            o_term_mv <= MV_4200;
            o_recharge_threshold_mv <= MV_4000;
            o_led_enable <= 1'b1;
            o_led_current_high <= 1'b1;
        end else begin
            o_charge_from_usb <= use_usb & i_usb_supply_input;
            o_eoc_current_ma <= ctl[CTL_EOC_BIT] ? 11'(full_rate_current / 11'(EOC_DIV_HIGH)) :
                                11'(full_rate_current / 11'(EOC_DIV_LOW));
            o_term_mv <= term_mv(ctl[CTL_TERM_HI:CTL_TERM_LO]);
            o_recharge_threshold_mv <= restart_mv(ctl[CTL_TERM_HI:CTL_TERM_LO]);
            o_led_enable <= spv[SPV_LED_EN_BIT - SPV_RANGE_BIT];
            o_led_current_high <= spv[SPV_LED_CUR_BIT - SPV_RANGE_BIT];
        end
    end

    // expiry flag stays up until a restart event; the pulse marks the moment
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_safety_timer_expired <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_irq <= expire & (next_state == ST_TIMER_EXP);
            if (expire & (next_state == ST_TIMER_EXP)) begin
                o_safety_timer_expired <= 1'b1;
            end else if (timer_restart) begin
                o_safety_timer_expired <= 1'b0;
            end
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cv_eoc;
        state == ST_CV && i_eoc_reached && src && en && temp_ok && !i_thermal_shutdown && !expire;
    endsequence
    sequence s_topoff_code;
        o_charge_state == CODE_TOPOFF;
    endsequence

    AST_EN_OFF: assert property (!en && !$past(en) |-> o_charge_state == CODE_OFF &&
        !o_charge_pass_transistor)
        else $error("charging not halted with enable clear");
    AST_PREQUAL_CODE: assert property (state == ST_PREQUAL |-> o_charge_state == CODE_PREQUAL)
        else $error("prequal code wrong");
    AST_PREQUAL_EXIT: assert property (state == ST_PREQUAL && i_batt_above_fullrate && src &&
        en && temp_ok && !i_thermal_shutdown && !expire |=> o_charge_state == CODE_CC)
        else $error("prequal did not leave to full rate");
    AST_CC_TO_CV: assert property (state == ST_CC && i_batt_at_term && src && en && temp_ok &&
        !i_thermal_shutdown && !expire |=> state == ST_CV ##0 o_charge_state == CODE_CV)
        else $error("no move to constant voltage");
    AST_TOPOFF_ENTRY: assert property (s_cv_eoc |=> s_topoff_code)
        else $error("top-off not entered");
    AST_DONE_OFF: assert property (state == ST_DONE |-> !o_charge_pass_transistor &&
        o_charge_state == CODE_DONE)
        else $error("charging active in cycle complete");
    AST_RECHARGE: assert property (state == ST_DONE && i_batt_below_restart && src && en
        |=> state == ST_CC && safety_sec == '0)
        else $error("recharge did not resume at full rate");
    AST_TEMP_SUSPEND: assert property (!temp_ok && src && en && charging |=>
        o_charge_state == CODE_ERROR && !o_charge_pass_transistor)
        else $error("out of range temperature did not suspend");
    AST_EXPIRE_IRQ: assert property (expire && src && en && temp_ok &&
        !i_thermal_shutdown && !timer_restart |=> o_irq ##1 !o_irq && o_safety_timer_expired)
        else $error("timer expiry not reported");
    AST_TIMER_HOLD: assert property (state == ST_TIMER_EXP && src && en && !timer_restart
        |=> state == ST_TIMER_EXP && o_charge_state == CODE_TIMER)
        else $error("left expiry without restart");
    AST_PREQUAL_LIMIT: assert property (state == ST_PREQUAL |->
        safety_sec <= SEC_W'(PREQUAL_LIMIT_S))
        else $error("prequal ran past its limit");
    AST_ENABLE_RESTART: assert property (en && !en_prev |=> safety_sec == '0)
        else $error("enable toggle did not clear timer");
    AST_ADAPTER_FIRST: assert property (i_adapter_supply_input |=> !o_charge_from_usb)
        else $error("usb chosen while adapter present");
endmodule : li_ion_charge_sequencer
`default_nettype wire

// >>> batt_env_model.sv
// battery and thermistor comparators that face the charge sequencer
// assumes the bench moves millivolts and degrees off the clock edge
`default_nettype none
module batt_env_model (
    input wire logic [12:0] i_batt_mv,
    input wire logic signed [7:0] i_temp_c,
    input wire logic i_unplugged,
    input wire logic [12:0] i_term_mv,
    input wire logic [12:0] i_recharge_mv,
    output logic o_above_fullrate,
    output logic o_at_term,
    output logic o_below_restart,
    output logic o_cold_trip,
    output logic o_cold_clear,
    output logic o_hot45_trip,
    output logic o_hot45_clear,
    output logic o_hot50_trip,
    output logic o_hot50_clear,
    output logic o_ts_float
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_above_fullrate = i_batt_mv >= 13'h0B22;
    assign o_at_term = i_batt_mv >= i_term_mv;
    assign o_below_restart = i_batt_mv < i_recharge_mv;
    // a floating pin reads as colder than the low limit, never as in range
    assign o_ts_float = i_unplugged;
    assign o_cold_trip = i_unplugged || i_temp_c < 8'sh00;
    assign o_cold_clear = !i_unplugged && i_temp_c > 8'sh03;
    assign o_hot45_trip = !i_unplugged && i_temp_c > 8'sh2D;
    assign o_hot45_clear = i_unplugged || i_temp_c < 8'sh2A;
    assign o_hot50_trip = !i_unplugged && i_temp_c > 8'sh32;
    assign o_hot50_clear = i_unplugged || i_temp_c < 8'sh2F;
endmodule : batt_env_model
`default_nettype wire

// >>> li_ion_charge_sequencer_test.sv
// self-checking bench for the charge sequencer, one second per clock
// assumes the comparator model in batt_env_model
`default_nettype none
module li_ion_charge_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import charge_seq_pkg::*;
    logic clk, rstn, wr, rd, adp, usb, susp, tsd, eoc, unplug, irq_seen;
    logic [7:0] addr, wdata, rdata, d;
    logic [12:0] mv, term_mv, rch_mv;
    logic signed [7:0] temp;
    logic [2:0] code;
    logic pass_on, from_usb, led_en, led_hi, expired, irq;
    logic [10:0] cur_ma, eoc_ma;
    logic above, at_term, below, ct, cc, h45t, h45c, h50t, h50c, flt;
    int miscompares, total_checks, seed, n;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    li_ion_charge_sequencer #(.CYCLES_PER_SEC(1)) u_dut (.i_clk(clk), .i_rstn(rstn),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_adapter_supply_input(adp), .i_usb_supply_input(usb), .i_usb_suspend_input(susp),
        .i_batt_above_fullrate(above), .i_batt_at_term(at_term), .i_batt_below_restart(below),
        .i_eoc_reached(eoc), .i_thermal_shutdown(tsd), .i_cold_trip(ct), .i_cold_clear(cc),
        .i_hot45_trip(h45t), .i_hot45_clear(h45c), .i_hot50_trip(h50t), .i_hot50_clear(h50c),
        .i_ts_float(flt), .o_reg_rdata(rdata), .o_charge_state(code),
        .o_charge_pass_transistor(pass_on), .o_charge_from_usb(from_usb),
        .o_charge_current_ma(cur_ma), .o_eoc_current_ma(eoc_ma), .o_term_mv(term_mv),
        .o_recharge_threshold_mv(rch_mv), .o_led_enable(led_en), .o_led_current_high(led_hi),
        .o_safety_timer_expired(expired), .o_irq(irq));
    batt_env_model u_env (.i_batt_mv(mv), .i_temp_c(temp), .i_unplugged(unplug),
        .i_term_mv(term_mv), .i_recharge_mv(rch_mv), .o_above_fullrate(above),
        .o_at_term(at_term), .o_below_restart(below), .o_cold_trip(ct), .o_cold_clear(cc),
        .o_hot45_trip(h45t), .o_hot45_clear(h45c), .o_hot50_trip(h50t), .o_hot50_clear(h50c),
        .o_ts_float(flt));
    always @(posedge clk) irq_seen <= irq_seen | (irq === 1'b1);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = v;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask : reg_read
    // bounded wait; n keeps the cycles taken for timing checks
    task automatic wait_code(input logic [2:0] c, input int lim);
        n = 0;
        while (code !== c && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(code, c);
    endtask : wait_code
    function automatic logic [12:0] term_of(input logic [1:0] t);
        return (t == 2'h0) ? MV_4100 : (t == 2'h2) ? MV_4380 : MV_4200;
    endfunction : term_of
    function automatic logic [12:0] rch_of(input logic [1:0] t);
        return (t == 2'h0) ? MV_3900 : (t == 2'h2) ? MV_4200 : MV_4000;
    endfunction : rch_of
    function automatic logic [10:0] eoc_of(input logic [7:0] v);
        int ma;
        ma = ((v[5:2] > 4'h9) ? 10 : v[5:2] + 1) * 100;
        return 11'(ma / (v[0] ? 10 : 20));
    endfunction : eoc_of
    task automatic print_verdict;
        if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        #(60_000 * 100);
        miscompares++;
        print_verdict();
    end
    initial begin
        {rstn, wr, rd, adp, usb, susp, tsd, eoc, unplug, irq_seen} = 10'h000;
        addr = 8'h00;
        wdata = 8'h00;
        mv = 13'h09C4;
        temp = 8'sh19;
        seed = 13;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        reg_read(ADDR_CHARGE_CONTROL, 8'h43);
        reg_read(ADDR_CHARGER_SUPERVISOR, 8'h30);
        reg_read(8'h07, 8'h00);
        check(rch_mv, MV_4000);
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[7:6] = 2'(i);
            reg_write(ADDR_CHARGE_CONTROL, d);
            reg_write(ADDR_CHARGER_SUPERVISOR, d);
            reg_read(ADDR_CHARGE_CONTROL, d);
            reg_read(ADDR_CHARGER_SUPERVISOR, {2'h0, d[5:3], CODE_OFF});
            check({led_hi, led_en}, d[5:4]);
            check(term_mv, term_of(d[7:6]));
            check(rch_mv, rch_of(d[7:6]));
            check(eoc_ma, eoc_of(d));
        end
        reg_write(ADDR_CHARGER_SUPERVISOR, 8'h30);
        reg_write(ADDR_CHARGE_CONTROL, 8'h67);
        adp = 1'b1;
        wait_code(CODE_PREQUAL, 10);
        check(cur_ma, 11'h064);
        mv = 13'h0BB8;
        wait_code(CODE_CC, 10);
        check(cur_ma, 11'h3E8);
        mv = 13'h1068;
        wait_code(CODE_CV, 10);
        reg_write(ADDR_CHARGER_SUPERVISOR, 8'h38);
        temp = 8'sh30;
        wait_code(CODE_ERROR, 10);
        temp = 8'sh2B;
        repeat (6) @(negedge clk);
        check(code, CODE_ERROR);
        temp = 8'sh28;
        wait_code(CODE_CV, 10);
        eoc = 1'b1;
        wait_code(CODE_TOPOFF, 10);
        wait_code(CODE_DONE, 1400);
        check(n > 1255 && n < 1265, 1'b1);
        check(pass_on, 1'b0);
        eoc = 1'b0;
        mv = 13'h0FD2;
        repeat (6) @(negedge clk);
        check(code, CODE_DONE);
        mv = 13'h0F6E;
        wait_code(CODE_CC, 10);
        unplug = 1'b1;
        wait_code(CODE_ERROR, 10);
        unplug = 1'b0;
        reg_write(ADDR_CHARGE_CONTROL, 8'h65);
        wait_code(CODE_OFF, 10);
        check(pass_on, 1'b0);
        mv = 13'h09C4;
        reg_write(ADDR_CHARGE_CONTROL, 8'h67);
        wait_code(CODE_PREQUAL, 10);
        wait_code(CODE_TIMER, 3700);
        check(n > 3585 && n < 3605, 1'b1);
        check({expired, irq}, 2'h3);
        @(negedge clk);
        check({expired, irq_seen, irq}, 3'h6);
        reg_write(ADDR_CHARGE_CONTROL, 8'h65);
        reg_write(ADDR_CHARGE_CONTROL, 8'h67);
        wait_code(CODE_PREQUAL, 10);
        check(expired, 1'b0);
        usb = 1'b1;
        adp = 1'b0;
        repeat (3) @(negedge clk);
        check({from_usb, cur_ma}, {1'b1, USB_PREQUAL_MA});
        adp = 1'b1;
        repeat (3) @(negedge clk);
        check(from_usb, 1'b0);
        tsd = 1'b1;
        wait_code(CODE_ERROR, 10);
        mv = 13'h0BB8;
        tsd = 1'b0;
        wait_code(CODE_CC, 10);
        wait_code(CODE_TIMER, 36100);
        check(n > 35990 && n < 36010, 1'b1);
        print_verdict();
    end
endmodule : li_ion_charge_sequencer_test
`default_nettype wire
